// >>> adc_clk_dec_pkg.sv
// Purpose: Shared constants and types for the clock selection and decimation block
// Assumes: Main clock and modulator rates are produced as enables on ref_clk
// Notes: Field encodings for mux, power mode and ratio live here
package adc_clk_dec_pkg;
  localparam int CHANNELS = 2;
  localparam int RESULT_WIDTH = 24;
  localparam int ACC_WIDTH = 48;
  localparam logic [1:0] INPUT_PINS = 2'h0;
  localparam logic [1:0] INPUT_GROUND = 2'h1;
  localparam logic [1:0] INPUT_TEST_POS = 2'h2;
  localparam logic [1:0] INPUT_TEST_NEG = 2'h3;
  localparam logic [1:0] HIGH_RESOLUTION_MODE = 2'h0;
  localparam logic [1:0] LOW_POWER_MODE = 2'h1;
  localparam logic [1:0] VERY_LOW_POWER_MODE = 2'h2;
  localparam logic [2:0] DIV_HR = 3'h1;
  localparam logic [2:0] DIV_LP = 3'h2;
  localparam logic [2:0] DIV_VLP = 3'h4;
  localparam int MOD_DIVIDE = 2;
  localparam int BASE_RATIO_LOG2 = 7;
  localparam int SINC3_MAX_LOG2 = 10;
  localparam logic [2:0] SPLIT_CODE = 3'h4;
  localparam logic [1:0] FAST_CONVERSIONS = 2'h2;
  // Test level is 2/15 of full scale
  localparam logic [RESULT_WIDTH-1:0] TEST_LEVEL = 24'h111111;
  localparam logic [RESULT_WIDTH-1:0] TEST_LEVEL_NEG = 24'hEEEEEF;
  typedef struct packed {
    logic [1:0] channel_input_select;
    logic enable;
  } channel_config_type;
  typedef struct packed {
    logic [RESULT_WIDTH-1:0] data;
    logic channel;
    logic fast_path;
  } result_type;
endpackage : adc_clk_dec_pkg

// >>> adc_clock_and_decimation.sv
// Purpose: Main clock selection, modulator timing and per-channel decimation
// Assumes: Oscillator and external clock arrive as pins sampled on ref_clk
// Notes: Results leave through a two-entry buffer with valid and ready
`timescale 1ns/1ns
`default_nettype none
module adc_clock_and_decimation
  import adc_clk_dec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Clock pins
  input wire logic external_clock_input,
  input wire logic oscillator_clock,
  output logic oscillator_enable,
  // Configuration
  input wire logic clock_source_select,
  input wire logic [1:0] power_mode_field,
  input wire logic [2:0] oversampling_ratio_field,
  input wire logic standby,
  input wire logic reference_settled,
  input wire channel_config_type [CHANNELS-1:0] channel_config,
  // Modulator bits
  input wire logic [CHANNELS-1:0] modulator_bit,
  output logic modulator_strobe,
  // Result stream
  output result_type result,
  output logic result_valid,
  input wire logic result_ready,
  output logic [CHANNELS-1:0] overflow
);
  logic [1:0] ext_sync, osc_sync, ref_sync;
  logic ext_last, osc_last, main_tick, mod_phase, mod_tick;
  logic [2:0] div_count;
  logic [2:0] divide;
  logic [2:0] sinc3_log2;
  logic [3:0] sinc3_bits;
  logic [2:0] sinc1_bits;
  logic [14:0] sinc3_len;
  logic [4:0] sinc1_len;
  logic [14:0] mod_count;
  logic [4:0] sinc1_count;
  logic [1:0] conv_count;
  logic [ACC_WIDTH-1:0] i1 [CHANNELS], i2 [CHANNELS], i3 [CHANNELS];
  logic [ACC_WIDTH-1:0] d1 [CHANNELS], d2 [CHANNELS], d3 [CHANNELS];
  logic [ACC_WIDTH-1:0] s1 [CHANNELS], fast [CHANNELS], sum1 [CHANNELS];
  result_type buf_word [2];
  logic [1:0] buf_full;
  logic buf_rd, buf_wr, pending, pend_fast;
  logic [CHANNELS-1:0] pend_mask;
  logic [RESULT_WIDTH-1:0] pend_data [CHANNELS];
  function automatic logic [ACC_WIDTH-1:0] bit_value(input logic b);
    bit_value = b ? ACC_WIDTH'(1) : {ACC_WIDTH{1'b1}};
  endfunction : bit_value
  // Bring a sum of gain two to the gain_log2 to full scale; short ratios need a left shift
  function automatic logic [RESULT_WIDTH-1:0] scale(input logic [ACC_WIDTH-1:0] v,
                                                     input logic [5:0] gain_log2);
    logic [ACC_WIDTH-1:0] t;
    if (gain_log2 >= 6'(RESULT_WIDTH - 1)) begin
      t = ACC_WIDTH'($signed(v) >>> (gain_log2 - 6'(RESULT_WIDTH - 1)));
    end else begin
      t = v << (6'(RESULT_WIDTH - 1) - gain_log2);
    end
    scale = t[RESULT_WIDTH-1:0];
  endfunction : scale
  // Pin synchronisers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_sync <= 2'h0;
      osc_sync <= 2'h0;
      ref_sync <= 2'h0;
      ext_last <= 1'b0;
      osc_last <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], external_clock_input};
      osc_sync <= {osc_sync[0], oscillator_clock};
      ref_sync <= {ref_sync[0], reference_settled};
      ext_last <= ext_sync[1];
      osc_last <= osc_sync[1];
    end
  end
  // Oscillator stays off until the source bit asks for it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      oscillator_enable <= 1'b0;
    end else begin
      oscillator_enable <= clock_source_select;
    end
  end
  always_comb begin
    unique case (power_mode_field)
      LOW_POWER_MODE: divide = DIV_LP;
      VERY_LOW_POWER_MODE: divide = DIV_VLP;
      default: divide = DIV_HR;
    endcase
  end
  // No glitch-free switching: host must stand by before changing source or mode
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_count <= 3'h0;
      main_tick <= 1'b0;
    end else if (!clock_source_select) begin
      div_count <= 3'h0;
      main_tick <= ext_sync[1] & ~ext_last;
    end else if (osc_sync[1] & ~osc_last) begin
      if (div_count + 3'h1 >= divide) begin
        div_count <= 3'h0;
        main_tick <= 1'b1;
      end else begin
        div_count <= div_count + 3'h1;
        main_tick <= 1'b0;
      end
    end else begin
      main_tick <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mod_phase <= 1'b0;
      mod_tick <= 1'b0;
    end else begin
      if (main_tick) begin
        mod_phase <= ~mod_phase;
      end
      mod_tick <= main_tick & mod_phase & ~standby;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      modulator_strobe <= 1'b0;
    end else begin
      modulator_strobe <= mod_tick;
    end
  end
  // Ratio code ascends by powers of two; sinc3 saturates at 1024
  always_comb begin
    sinc3_log2 = (oversampling_ratio_field >= SPLIT_CODE) ? 3'(SINC3_MAX_LOG2 - BASE_RATIO_LOG2)
                                                          : oversampling_ratio_field;
    sinc3_bits = 4'(sinc3_log2) + 4'(BASE_RATIO_LOG2);
    sinc1_bits = (oversampling_ratio_field >= SPLIT_CODE) ?
                 oversampling_ratio_field - SPLIT_CODE + 3'h1 : 3'h0;
    sinc3_len = 15'(1) << sinc3_bits;
    sinc1_len = 5'h1 << sinc1_bits;
  end
  // At-or-past ends, so a shorter ratio picked mid-count cannot run a counter round
  wire sinc3_done = mod_tick && (mod_count >= sinc3_len - 15'h1);
  wire word_done = sinc3_done && (sinc1_count >= sinc1_len - 5'h1);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mod_count <= 15'h0;
      sinc1_count <= 5'h0;
    end else if (mod_tick) begin
      mod_count <= sinc3_done ? 15'h0 : mod_count + 15'h1;
      if (sinc3_done) begin
        sinc1_count <= word_done ? 5'h0 : sinc1_count + 5'h1;
      end
    end
  end
  // Filter per channel: sinc3 integrators with decimated combs, plus fast sinc1
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        i1[c] <= '0;
        i2[c] <= '0;
        i3[c] <= '0;
        d1[c] <= '0;
        d2[c] <= '0;
        d3[c] <= '0;
        s1[c] <= '0;
        fast[c] <= '0;
      end
    end else if (mod_tick) begin
      for (int c = 0; c < CHANNELS; c++) begin
        logic [ACC_WIDTH-1:0] x;
        logic [ACC_WIDTH-1:0] c1;
        logic [ACC_WIDTH-1:0] c2;
        logic [ACC_WIDTH-1:0] c3;
        x = bit_value(modulator_bit[c]);
        c1 = i3[c] - d1[c];
        c2 = c1 - d2[c];
        c3 = c2 - d3[c];
        i1[c] <= i1[c] + x;
        i2[c] <= i2[c] + i1[c] + x;
        i3[c] <= i3[c] + i2[c] + i1[c] + x;
        fast[c] <= word_done ? '0 : fast[c] + x;
        if (sinc3_done) begin
          d1[c] <= i3[c];
          d2[c] <= c1;
          d3[c] <= c2;
          s1[c] <= word_done ? '0 : s1[c] + c3;
        end
      end
    end
  end
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      sum1[c] = s1[c] + (i3[c] - d1[c] - d2[c] - d3[c]);
    end
  end
  // Conversion counter picks the path; stays on sinc3 until reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_count <= 2'h0;
    end else if (word_done && ref_sync[1] && conv_count != FAST_CONVERSIONS) begin
      conv_count <= conv_count + 2'h1;
    end
  end
  // Capture a conversion; gated on the synchronised reference settled flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b0;
      pend_mask <= '0;
      pend_fast <= 1'b0;
      overflow <= '0;
      for (int c = 0; c < CHANNELS; c++) begin
        pend_data[c] <= '0;
      end
    end else if (word_done && ref_sync[1]) begin
      pending <= 1'b1;
      pend_fast <= conv_count != FAST_CONVERSIONS;
      for (int c = 0; c < CHANNELS; c++) begin
        pend_mask[c] <= channel_config[c].enable;
        overflow[c] <= pend_mask[c];
        unique case (channel_config[c].channel_input_select)
          INPUT_TEST_POS: pend_data[c] <= TEST_LEVEL;
          INPUT_TEST_NEG: pend_data[c] <= TEST_LEVEL_NEG;
          INPUT_GROUND: pend_data[c] <= '0;
          default: pend_data[c] <= (conv_count != FAST_CONVERSIONS) ?
            scale(fast[c] + bit_value(modulator_bit[c]), 6'(sinc3_bits) + 6'(sinc1_bits))
            : scale(sum1[c], 6'(3 * sinc3_bits) + 6'(sinc1_bits));
        endcase
      end
    end else if (pending && buf_wr) begin
      pend_mask <= pend_mask & (pend_mask - CHANNELS'(1));
      if ((pend_mask & (pend_mask - CHANNELS'(1))) == '0) begin
        pending <= 1'b0;
      end
    end else if (pending && pend_mask == '0) begin
      pending <= 1'b0;
    end
  end
  // Two-entry buffer; a stalled receiver backs up into the pending word
  wire pick = ~pend_mask[0];
  assign buf_rd = result_valid & result_ready;
  assign buf_wr = pending && pend_mask != '0 && (buf_full != 2'h3 || buf_rd);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      buf_full <= 2'h0;
      buf_word[0] <= '0;
      buf_word[1] <= '0;
    end else begin
      if (buf_rd) begin
        buf_word[0] <= buf_word[1];
      end
      if (buf_wr) begin
        buf_word[(buf_full[0] && !buf_rd) ? 1 : (buf_full[1] ? 1 : 0)] <=
          '{data: pend_data[pick], channel: pick, fast_path: pend_fast};
      end
      unique case ({buf_wr, buf_rd})
        2'b10: buf_full <= {buf_full[0], 1'b1};
        2'b01: buf_full <= {1'b0, buf_full[1]};
        default: buf_full <= buf_full;
      endcase
    end
  end
  // Head entry is the output register; a copy a cycle behind would repeat a popped word
  assign result = buf_word[0];
  assign result_valid = buf_full[0];
endmodule : adc_clock_and_decimation
`default_nettype wire

// >>> adc_clk_dec_assertions.sv
// Purpose: Concurrent checks on the clock selection and decimation ports
// Assumes: Both channels stay enabled once results start
// Notes: Conversion count saturates at three, enough to see the filter handover
`timescale 1ns/1ns
`default_nettype none
module adc_clk_dec_checker
  import adc_clk_dec_pkg::*;
(
  // Clock, reset and configuration
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clock_source_select,
  input wire logic external_clock_input,
  input wire channel_config_type [CHANNELS-1:0] channel_config,
  input wire logic reference_settled,
  input wire logic result_ready,
  // Observed outputs
  input wire logic oscillator_enable,
  input wire logic modulator_strobe,
  input wire result_type result,
  input wire logic result_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [1:0] conv;
  logic last_ch;
  sequence taken;
    result_valid && result_ready;
  endsequence
  sequence stalled;
    result_valid && !result_ready;
  endsequence
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv <= 2'h0;
      last_ch <= 1'b0;
    end else if (result_valid && result_ready) begin
      last_ch <= result.channel;
      if (result.channel && conv != 2'h3) begin
        conv <= conv + 2'h1;
      end
    end
  end
  AST_NO_EARLY: assert property (result_valid |-> $past(reference_settled, 3))
    else $error("result before reference settled");
  AST_OSC_ON: assert property ($rose(clock_source_select) |-> ##[0:2] oscillator_enable)
    else $error("oscillator not enabled");
  AST_OSC_OFF: assert property (!clock_source_select [*3] |-> !oscillator_enable)
    else $error("oscillator on while unselected");
  AST_STROBE_RATE: assert property (modulator_strobe |=> !modulator_strobe [*3])
    else $error("modulator strobe too fast");
  AST_NO_CLOCK: assert property ((!clock_source_select && !external_clock_input) [*8]
    |-> !modulator_strobe)
    else $error("strobe without external clock");
  AST_HOLD: assert property (stalled |=> result_valid && $stable(result))
    else $error("result dropped while stalled");
  AST_ORDER: assert property (taken ##0 (result.channel && channel_config[0].enable)
    |-> !last_ch)
    else $error("channel order broken");
  AST_FAST_FIRST: assert property (taken ##0 (conv < 2'h2) |-> result.fast_path)
    else $error("early result not from fast path");
  AST_SINC_LATER: assert property (taken ##0 (conv >= 2'h2) |-> !result.fast_path)
    else $error("late result from fast path");
endmodule : adc_clk_dec_checker
`default_nettype wire

// >>> adc_host_clocks.sv
// Purpose: Host side clock sources for the converter block
// Assumes: Both clocks are generated on ref_clk edges
// Notes: A stopped clock sits at ground, never frozen high
`timescale 1ns/1ns
`default_nettype none
module adc_host_clocks (
  // Control
  input wire logic ref_clk,
  input wire logic ext_run,
  input wire logic oscillator_enable,
  // Clock pins
  output var logic external_clock_input,
  output var logic oscillator_clock
);
  logic [1:0] ph = 2'h0;
  initial begin
    external_clock_input = 1'b0;
    oscillator_clock = 1'b0;
  end
  always @(posedge ref_clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ph == 2'h2) begin
      external_clock_input <= ext_run & ~external_clock_input;
    end
    oscillator_clock <= oscillator_enable & ~oscillator_clock;
  end
endmodule : adc_host_clocks
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for clock selection and decimation
// Assumes: External clock period is six ref_clk cycles
// Notes: Ratio checks count strobes, so buffer latency cancels out
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import adc_clk_dec_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst, ext_run, sel, standby, settled, ready, stall, scoring;
  logic [1:0] pmode;
  logic [2:0] osr;
  logic [CHANNELS-1:0] mbit, ovf;
  channel_config_type [CHANNELS-1:0] cfg;
  logic osc_en, ext_clk, osc_clk, strobe, valid;
  result_type res;
  result_type exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int k, n;
  logic [31:0] seed = 32'h67F14F08;
  adc_host_clocks u_host (.ref_clk(ref_clk), .ext_run(ext_run), .oscillator_enable(osc_en),
    .external_clock_input(ext_clk), .oscillator_clock(osc_clk));
  adc_clock_and_decimation u_dut (.ref_clk(ref_clk), .nrst(nrst),
    .external_clock_input(ext_clk), .oscillator_clock(osc_clk), .oscillator_enable(osc_en),
    .clock_source_select(sel), .power_mode_field(pmode), .oversampling_ratio_field(osr),
    .standby(standby), .reference_settled(settled), .channel_config(cfg),
    .modulator_bit(mbit), .modulator_strobe(strobe), .result(res), .result_valid(valid),
    .result_ready(ready), .overflow(ovf));
  always #10 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test;
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Kind 0 counts cycles to a strobe, kind 1 counts strobes to a channel 0 word
  task automatic gap(input bit kind, output int s);
    int c;
    c = 0;
    s = 0;
    do begin
      @(negedge ref_clk);
      c++;
      s = s + (kind ? int'(strobe === 1'b1) : 1);
    end while ((kind ? (valid && ready && !res.channel) : strobe) !== 1'b1 && c < 20000);
    if (c >= 20000) begin
      error_cnt++;
      finish_test();
    end
  endtask : gap
  always @(posedge ref_clk) begin
    seed <= xs(seed);
    ready <= stall ? seed[0] : 1'b1;
    mbit <= seed[2:1];
    if (nrst && valid && ready && scoring && exp_q.size() > 0) begin
      check(32'(res), 32'(exp_q.pop_front()));
    end
  end
  initial begin
    nrst = 1'b0;
    ext_run = 1'b0;
    sel = 1'b0;
    standby = 1'b0;
    settled = 1'b0;
    stall = 1'b0;
    scoring = 1'b0;
    pmode = HIGH_RESOLUTION_MODE;
    osr = 3'h0;
    cfg = '0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    ext_run <= 1'b1;
    cfg <= {{INPUT_TEST_NEG, 1'b1}, {INPUT_TEST_POS, 1'b1}};
    @(negedge ref_clk);
    check(osc_en, 1'b0);
    gap(0, n);
    gap(0, n);
    check(n, 12);
    repeat (2000) @(posedge ref_clk);
    check(valid, 1'b0);
    for (k = 0; k < 4; k++) begin
      exp_q.push_back('{data: TEST_LEVEL, channel: 1'b0, fast_path: k < 2});
      exp_q.push_back('{data: TEST_LEVEL_NEG, channel: 1'b1, fast_path: k < 2});
    end
    settled <= 1'b1;
    stall <= 1'b1;
    scoring <= 1'b1;
    n = 0;
    while (exp_q.size() > 0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    check(n < 20000, 1'b1);
    @(posedge ref_clk);
    scoring <= 1'b0;
    stall <= 1'b0;
    standby <= 1'b1;
    @(posedge ref_clk);
    sel <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ext_run <= 1'b0;
    check(osc_en, 1'b1);
    for (k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      pmode <= 2'(k);
      @(posedge ref_clk);
      standby <= 1'b0;
      gap(0, n);
      gap(0, n);
      check(n, 32'(4 << k));
      @(posedge ref_clk);
      standby <= 1'b1;
    end
    @(posedge ref_clk);
    pmode <= HIGH_RESOLUTION_MODE;
    @(posedge ref_clk);
    standby <= 1'b0;
    cfg <= {{INPUT_PINS, 1'b1}, {INPUT_PINS, 1'b1}};
    for (k = 0; k < 5; k++) begin
      @(posedge ref_clk);
      osr <= 3'(k);
      gap(1, n);
      gap(1, n);
      gap(1, n);
      check(n, 32'(128 << k));
    end
    check(ovf, 2'h0);
    // Back to the external pin with it held low: no main clock, so no strobes
    standby <= 1'b1;
    @(posedge ref_clk);
    sel <= 1'b0;
    @(posedge ref_clk);
    standby <= 1'b0;
    repeat (8) @(posedge ref_clk);
    n = 0;
    repeat (40) begin
      @(negedge ref_clk);
      n = n + int'(strobe === 1'b1);
    end
    check(n, 0);
    check(osc_en, 1'b0);
    finish_test();
  end
endmodule : testbench
bind adc_clock_and_decimation adc_clk_dec_checker u_chk (.ref_clk, .nrst,
  .clock_source_select, .external_clock_input, .channel_config, .reference_settled,
  .result_ready, .oscillator_enable, .modulator_strobe, .result, .result_valid);
`default_nettype wire
